// ==== design/pac_consts.vh ====
// constants for the pulse accumulator counter: offsets, fields, resets, timing
`ifndef PAC_CONSTS_VH
`define PAC_CONSTS_VH

// register byte offsets on the apb bus
`define PAC_OFF_CTRL      8'h00
`define PAC_OFF_COUNT     8'h04
`define PAC_OFF_FLAGS     8'h08
`define PAC_OFF_IRQ_STAT  8'h0C
`define PAC_OFF_IRQ_MASK  8'h10
`define PAC_OFF_IRQ_SRC   8'h14

// control register fields
`define PAC_CTRL_EN       0
`define PAC_CTRL_MODE     1
`define PAC_CTRL_POL      2
`define PAC_CTRL_OVF_IE   4
`define PAC_CTRL_EDGE_IE  5

// flag fields, shared by the flag, status and mask registers except the pin bit, which only the flag register has
`define PAC_FLG_PIN       0
`define PAC_FLG_OVF       4
`define PAC_FLG_EDGE      5

// interrupt source codes, overflow ranks first
`define PAC_SRC_NONE      2'h0
`define PAC_SRC_OVF       2'h1
`define PAC_SRC_EDGE      2'h2

// reset values
`define PAC_RST_CTRL      6'h00
`define PAC_RST_COUNT     8'h00
`define PAC_RST_MASK      2'h0

// counter width and gated-mode divider
`define PAC_CNT_W         8
`define PAC_PRESCALE_W    6
`define PAC_PRESCALE_DIV  7'h40

`endif

// ==== design/pac_sync.v ====
// pin synchroniser with edge detection for the accumulator input
`timescale 1ns/100ps
`default_nettype none

module pac_sync
(
	input  wire clk_sys,   // system clock
	input  wire resetn,    // async reset, active low
	input  wire ce,        // clock enable
	input  wire pin_async, // raw pin
	output wire level,     // synchronised level
	output wire rise,      // one-cycle rising pulse
	output wire fall       // one-cycle falling pulse
);

	reg meta_r;  // first stage, read only by the second
	reg sync_r;  // second stage, safe to use
	reg prev_r;  // delayed copy for edge detection

	// two-flop chain, then one more for the edge compare
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else if (ce)
		begin
			meta_r <= pin_async;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise  = sync_r & ~prev_r;
	assign fall  = ~sync_r & prev_r;

endmodule // pac_sync

`default_nettype wire

// ==== design/pac_prescale.v ====
// free-running divider giving one tick every DIV system clocks
`timescale 1ns/100ps
`default_nettype none
`include "pac_consts.vh"

module pac_prescale
#(
	parameter         W   = `PAC_PRESCALE_W,  // counter width
	parameter [W:0]   DIV = `PAC_PRESCALE_DIV // division ratio
)
(
	input  wire clk_sys, // system clock
	input  wire resetn,  // async reset, active low
	input  wire ce,      // clock enable
	output reg  tick     // one-cycle pulse per period
);

	localparam [W:0] LAST = DIV - 1'b1; // terminal count

	reg [W-1:0] cnt_r; // divider state

	// free running: never restarted, so gate phase is arbitrary to the pin
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r <= {W{1'b0}};
			tick  <= 1'b0;
		end
		else if (ce)
		begin
			tick  <= (cnt_r == LAST[W-1:0]);
			cnt_r <= (cnt_r == LAST[W-1:0]) ? {W{1'b0}} : cnt_r + 1'b1;
		end
	end

endmodule // pac_prescale

`default_nettype wire

// ==== design/pac_top.v ====
// pulse accumulator counter with apb registers and one interrupt line
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pac_consts.vh"

module pac_top
#(
	parameter CNT_W  = `PAC_CNT_W, // counter width
	parameter ADDR_W = 8           // apb address width
)
(
	input  wire              clk_sys,         // system clock, 20 MHz
	input  wire              resetn,          // async reset, active low
	input  wire              ce,              // clock enable, freezes all state
	input  wire              psel,            // apb select
	input  wire              penable,         // apb access phase
	input  wire              pwrite,          // apb direction
	input  wire [ADDR_W-1:0] paddr,           // apb byte address
	input  wire [31:0]       pwdata,          // apb write data
	output reg  [31:0]       prdata,          // apb read data
	output reg               pready,          // apb ready
	output reg               pslverr,         // apb error, unmapped address
	input  wire              accum_input_pin, // external event or gate pin
	output reg               irq,             // level interrupt
	output reg  [1:0]        irq_src          // highest pending source
);

	// ---- helper functions

	// address compare, used by every register select
	function hit;
		input [ADDR_W-1:0] a;
		input [7:0]        off;
		begin
			// full-width compare, so no upper address bit aliases a register
			hit = ({{(32-ADDR_W){1'b0}}, a} == {24'h00_0000, off});
		end
	endfunction

	// sticky bit update where a set in the clearing cycle wins
	function next_flag;
		input cur;  // present value
		input set;  // hardware event
		input clr;  // software clear
		begin
			next_flag = set | (cur & ~clr);
		end
	endfunction

	// ---- registers

	reg [5:0]       ctrl_r;          // control bits
	reg [CNT_W-1:0] accum_counter_r; // the counter
	reg             ovf_flag_r;      // counter_overflow_flag
	reg             edge_flag_r;     // input_edge_flag
	reg [1:0]       irq_stat_r;      // sticky status, read clears
	reg [1:0]       irq_mask_r;      // status mask

	// control fields by name
	wire accum_enable         = ctrl_r[`PAC_CTRL_EN];
	wire accum_mode_select    = ctrl_r[`PAC_CTRL_MODE];
	wire edge_polarity_select = ctrl_r[`PAC_CTRL_POL];
	wire overflow_irq_enable  = ctrl_r[`PAC_CTRL_OVF_IE];
	wire edge_irq_enable      = ctrl_r[`PAC_CTRL_EDGE_IE];

	// ---- pin path

	wire pin_level; // synchronised pin
	wire pin_rise;  // rising pulse
	wire pin_fall;  // falling pulse

	// raw pin never reaches the counter logic directly
	pac_sync u_sync
	(
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.ce        (ce),
		.pin_async (accum_input_pin),
		.level     (pin_level),
		.rise      (pin_rise),
		.fall      (pin_fall)
	);

	wire div_tick; // one pulse per 64 clocks

	pac_prescale u_prescale
	(
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.ce      (ce),
		.tick    (div_tick)
	);

	// ---- count decision

	wire sel_edge;    // the edge software chose
	wire gate_open;   // pin at its active level
	wire count_event; // one increment this cycle
	wire wrap;        // increment from all-ones

	// polarity 1 picks rising, 0 picks falling
	assign sel_edge = edge_polarity_select ? pin_rise : pin_fall;

	// inhibit level equals the polarity bit, so count at the other level;
	// the trailing edge lands on the selected edge and closes the gate
	assign gate_open = (pin_level != edge_polarity_select);

	// mode 0 counts pin edges, mode 1 counts divided ticks while gated
	assign count_event = accum_enable &
		(accum_mode_select ? (div_tick & gate_open) : sel_edge);

	// a wrap raises the flag even on the final tick before the gate closes
	assign wrap = count_event & (&accum_counter_r);

	// ---- apb decode

	wire acc_phase; // access edge with ready
	wire wr_acc;    // write takes effect
	wire rd_acc;    // read completes

	assign acc_phase = psel & penable & pready;
	assign wr_acc    = acc_phase & pwrite;
	assign rd_acc    = acc_phase & ~pwrite;

	wire sel_ctrl  = hit(paddr, `PAC_OFF_CTRL);
	wire sel_count = hit(paddr, `PAC_OFF_COUNT);
	wire sel_flags = hit(paddr, `PAC_OFF_FLAGS);
	wire sel_stat  = hit(paddr, `PAC_OFF_IRQ_STAT);
	wire sel_mask  = hit(paddr, `PAC_OFF_IRQ_MASK);
	wire sel_src   = hit(paddr, `PAC_OFF_IRQ_SRC);
	wire mapped    = sel_ctrl | sel_count | sel_flags | sel_stat | sel_mask | sel_src;
	wire cnt_wr    = wr_acc & sel_count; // counter write, beats an increment

	// ---- flag and status next values

	wire ovf_set;   // overflow flag event
	wire edge_set;  // edge flag event
	wire ovf_clr;   // write one to bit 4
	wire edge_clr;  // write one to bit 5
	wire stat_clr;  // read of the status register

	// flags cannot set while the block is disabled; they keep their value
	// a wrap under a counter write is dropped here once, so that flag,
	// status and irq never disagree about it
	assign ovf_set  = wrap & ~cnt_wr;
	assign edge_set = accum_enable & sel_edge;
	assign ovf_clr  = wr_acc & sel_flags & pwdata[`PAC_FLG_OVF];
	assign edge_clr = wr_acc & sel_flags & pwdata[`PAC_FLG_EDGE];
	assign stat_clr = rd_acc & sel_stat;

	wire ovf_flag_nxt;  // next overflow flag
	wire edge_flag_nxt; // next edge flag
	wire [1:0] stat_nxt; // next sticky status

	assign ovf_flag_nxt  = next_flag(ovf_flag_r, ovf_set, ovf_clr);
	assign edge_flag_nxt = next_flag(edge_flag_r, edge_set, edge_clr);

	// a request is a flag rising while its local enable is set
	assign stat_nxt[0] = next_flag(irq_stat_r[0], ovf_set & overflow_irq_enable,
		stat_clr);
	assign stat_nxt[1] = next_flag(irq_stat_r[1], edge_set & edge_irq_enable,
		stat_clr);

	wire [1:0] pend_nxt = stat_nxt & irq_mask_r; // unmasked pending

	// ---- read mux

	reg [31:0] rdata_nxt; // data for the coming access

	// assembled at the setup cycle, so the value is the one seen at setup
	always @*
	begin
		rdata_nxt = 32'h0000_0000;
		if (sel_ctrl)
			rdata_nxt[5:0] = ctrl_r;
		else if (sel_count)
			rdata_nxt[CNT_W-1:0] = accum_counter_r;
		else if (sel_flags)
		begin
			rdata_nxt[`PAC_FLG_PIN]  = pin_level;
			rdata_nxt[`PAC_FLG_OVF]  = ovf_flag_r;
			rdata_nxt[`PAC_FLG_EDGE] = edge_flag_r;
		end
		else if (sel_stat)
		begin
			rdata_nxt[`PAC_FLG_OVF]  = irq_stat_r[0];
			rdata_nxt[`PAC_FLG_EDGE] = irq_stat_r[1];
		end
		else if (sel_mask)
		begin
			rdata_nxt[`PAC_FLG_OVF]  = irq_mask_r[0];
			rdata_nxt[`PAC_FLG_EDGE] = irq_mask_r[1];
		end
		else if (sel_src)
			rdata_nxt[1:0] = irq_src;
		else
			rdata_nxt = 32'h0000_0000; // unmapped reads zero
	end

	// ---- apb handshake

	// one wait-free access: ready rises for the access phase only
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (psel & ~penable)
			begin
				// setup cycle: prepare the answer
				pready  <= 1'b1;
				pslverr <= ~mapped;
				prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
			end
			else
			begin
				// access done or idle: drop the answer
				pready  <= 1'b0;
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
		end
	end

	// ---- control and mask registers

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r     <= `PAC_RST_CTRL;
			irq_mask_r <= `PAC_RST_MASK;
		end
		else if (ce)
		begin
			if (wr_acc & sel_ctrl)
			begin
				ctrl_r[`PAC_CTRL_EN]      <= pwdata[`PAC_CTRL_EN];
				ctrl_r[`PAC_CTRL_MODE]    <= pwdata[`PAC_CTRL_MODE];
				ctrl_r[`PAC_CTRL_POL]     <= pwdata[`PAC_CTRL_POL];
				ctrl_r[3]                 <= 1'b0; // unused, reads zero
				ctrl_r[`PAC_CTRL_OVF_IE]  <= pwdata[`PAC_CTRL_OVF_IE];
				ctrl_r[`PAC_CTRL_EDGE_IE] <= pwdata[`PAC_CTRL_EDGE_IE];
			end
			if (wr_acc & sel_mask)
			begin
				irq_mask_r[0] <= pwdata[`PAC_FLG_OVF];
				irq_mask_r[1] <= pwdata[`PAC_FLG_EDGE];
			end
		end
	end

	// ---- the counter

	// a software write beats a coincident increment: the preset is exact,
	// so a value of minus N overflows on the Nth count after it
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			accum_counter_r <= `PAC_RST_COUNT;
		else if (ce)
		begin
			if (wr_acc & sel_count)
				accum_counter_r <= pwdata[CNT_W-1:0];
			else if (count_event)
				accum_counter_r <= accum_counter_r + 1'b1;
			// otherwise hold: a reopened gate resumes from here
			else
				accum_counter_r <= accum_counter_r;
		end
	end

	// ---- flags

	// a wrap under a counter write never reaches ovf_set, so the plain
	// set-wins update is exact here
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ovf_flag_r  <= 1'b0;
			edge_flag_r <= 1'b0;
		end
		else if (ce)
		begin
			ovf_flag_r  <= ovf_flag_nxt;
			edge_flag_r <= edge_flag_nxt;
		end
	end

	// ---- interrupt status and output

	// status sets win over the clear-on-read in the same cycle
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_stat_r <= 2'h0;
			irq        <= 1'b0;
			irq_src    <= `PAC_SRC_NONE;
		end
		else if (ce)
		begin
			irq_stat_r <= stat_nxt;
			irq        <= |pend_nxt;
			// overflow first so a just-in-time wrap is served before the edge
			if (pend_nxt[0])
				irq_src <= `PAC_SRC_OVF;
			else if (pend_nxt[1])
				irq_src <= `PAC_SRC_EDGE;
			else
				irq_src <= `PAC_SRC_NONE;
		end
	end

	// note: irq and irq_src are loaded from the same next-state values as
	// the status register, so all three change at the same edge;
	// a mask write only reaches irq one edge after the mask itself
	// changes, since the mask is taken from its register

endmodule // pac_top

`default_nettype wire

// ==== dv/pac_top_assertions.sv ====
// concurrent checks on the accumulator apb and interrupt ports
`timescale 1ns/100ps
`default_nettype none

module pac_top_chk
(
	input wire logic        clk_sys, // system clock
	input wire logic        resetn,  // async reset, active low
	input wire logic        ce,      // clock enable
	input wire logic        psel,    // apb select
	input wire logic        penable, // apb access phase
	input wire logic [31:0] prdata,  // read data
	input wire logic        pready,  // ready
	input wire logic        pslverr, // error
	input wire logic        irq,     // interrupt line
	input wire logic [1:0]  irq_src  // pending source
);
	// frozen state under ce low would stretch every figure
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn || !ce);

	// setup phase of a transfer
	sequence setup_s;
		psel && !penable;
	endsequence

	// completed access phase
	sequence access_s;
		psel && penable && pready;
	endsequence

	setup_ready_a: assert property (setup_s |=> pready)
		else $error("no ready in cycle after setup");
	ready_once_a: assert property (access_s |=> !pready)
		else $error("ready held past one cycle");
	ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("ready without setup");
	err_in_ready_a: assert property (pslverr |-> pready)
		else $error("error outside access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero when idle");
	err_rdata_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("unmapped read returned data");
	src_code_a: assert property (irq_src != 2'h3)
		else $error("illegal source code");
	irq_fall_a: assert property ($fell(irq) |-> $past(pready))
		else $error("interrupt dropped without software access");
	irq_match_a: assert property (irq == (irq_src != 2'h0))
		else $error("interrupt line and source code disagree");
endmodule // pac_top_chk

bind pac_top pac_top_chk pac_top_chk_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .irq_src(irq_src));

`default_nettype wire

// ==== dv/pac_pulse_src.sv ====
// pulse source model driving the accumulator input pin
`timescale 1ns/100ps
`default_nettype none

module pac_pulse_src
(
	input  wire logic clk_sys, // bench clock
	output var  logic pin      // accumulator input, idles low
);
	initial pin = 1'b0; // idle level before any pulse

	// drive level v, then hold it for w clocks
	task hold(input logic v, input int w);
		begin
			pin <= v;
			repeat (w) @(posedge clk_sys);
		end
	endtask

	// n pulses, high w clocks then low w clocks; w of 2 or more keeps edge spacing
	task pulse(input int n, input int w);
		begin
			repeat (n)
			begin
				hold(1'b1, w);
				hold(1'b0, w);
			end
		end
	endtask
endmodule // pac_pulse_src

`default_nettype wire

// ==== dv/test_pac_top.sv ====
// self-checking bench for the pulse accumulator counter
`timescale 1ns/100ps
`default_nettype none
`include "pac_consts.vh"

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module test_pac_top;
	logic        clk_sys;    // 50 ns clock
	logic        resetn;     // active low reset
	logic        ce;         // clock enable, dropped once to test freezing
	logic        psel;       // apb select
	logic        penable;    // apb enable
	logic        pwrite;     // apb direction
	logic [7:0]  paddr;      // apb address
	logic [31:0] pwdata;     // apb write data
	wire  [31:0] prdata;     // apb read data
	wire         pready;     // apb ready
	wire         pslverr;    // apb error
	wire         pin;        // accumulator input
	wire         irq;        // interrupt line
	wire  [1:0]  irq_src;    // pending source
	int          error_cnt;  // mismatches
	int          num_checks; // comparisons
	int          cyc = 0;    // cycles for timeout
	logic [31:0] rd;         // last read data
	logic        er;         // last error flag

	pac_top pac_top_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .accum_input_pin(pin),
		.irq(irq), .irq_src(irq_src));

	pac_pulse_src pac_pulse_src_i (.clk_sys(clk_sys), .pin(pin));

	// free-running clock
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// verdict and end of run
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// hang guard, the run needs under two thousand cycles
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test;
		end
	end

	// one apb transfer, entered just after a rising edge; an idle cycle
	// follows so the next call never drives psel twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			do @(posedge clk_sys); while (pready !== 1'b1);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk_sys);
		end
	endtask

	// read and compare
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			`CHK(rd, e)
		end
	endtask

	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		resetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		// reset values, then an unmapped address
		rd_chk(`PAC_OFF_CTRL, 32'h0);
		rd_chk(`PAC_OFF_COUNT, 32'h0);
		rd_chk(`PAC_OFF_IRQ_MASK, 32'h0);
		rd_chk(8'h40, 32'h0);
		`CHK(er, 1'b1)
		$display("test reset done");
		// preset minus three, rising edges, wrap with both requests pending
		apb(1'b1, `PAC_OFF_COUNT, 32'hFD);
		apb(1'b1, `PAC_OFF_IRQ_MASK, 32'h30);
		apb(1'b1, `PAC_OFF_CTRL, 32'h35);
		pac_pulse_src_i.pulse(3, 4);
		rd_chk(`PAC_OFF_COUNT, 32'h0);
		rd_chk(`PAC_OFF_FLAGS, 32'h30);
		`CHK(irq, 1'b1)
		rd_chk(`PAC_OFF_IRQ_SRC, 32'h1);
		rd_chk(`PAC_OFF_IRQ_STAT, 32'h30);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		apb(1'b1, `PAC_OFF_FLAGS, 32'h30);
		rd_chk(`PAC_OFF_FLAGS, 32'h0);
		$display("test overflow done");
		// edge request masked, then unmasked
		apb(1'b1, `PAC_OFF_IRQ_MASK, 32'h0);
		pac_pulse_src_i.pulse(1, 4);
		`CHK(irq, 1'b0)
		apb(1'b1, `PAC_OFF_IRQ_MASK, 32'h20);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		rd_chk(`PAC_OFF_IRQ_SRC, 32'h2);
		rd_chk(`PAC_OFF_COUNT, 32'h1);
		rd_chk(`PAC_OFF_IRQ_STAT, 32'h20);
		$display("test mask done");
		// falling edges, then disabled counter keeps value and flags
		apb(1'b1, `PAC_OFF_FLAGS, 32'h30);
		apb(1'b1, `PAC_OFF_CTRL, 32'h01);
		pac_pulse_src_i.pulse(2, 6);
		rd_chk(`PAC_OFF_COUNT, 32'h3);
		rd_chk(`PAC_OFF_FLAGS, 32'h20);
		apb(1'b1, `PAC_OFF_FLAGS, 32'h30);
		apb(1'b1, `PAC_OFF_CTRL, 32'h00);
		pac_pulse_src_i.pulse(2, 6);
		rd_chk(`PAC_OFF_COUNT, 32'h3);
		rd_chk(`PAC_OFF_FLAGS, 32'h0);
		$display("test polarity done");
		// gated, low inhibits: idle, wrap on the second of four ticks, resume
		apb(1'b1, `PAC_OFF_COUNT, 32'hFE);
		apb(1'b1, `PAC_OFF_CTRL, 32'h03);
		repeat (200) @(posedge clk_sys);
		rd_chk(`PAC_OFF_COUNT, 32'hFE);
		pac_pulse_src_i.pulse(1, 256);
		rd_chk(`PAC_OFF_COUNT, 32'h2);
		rd_chk(`PAC_OFF_FLAGS, 32'h30);
		pac_pulse_src_i.pulse(1, 128);
		rd_chk(`PAC_OFF_COUNT, 32'h4);
		$display("test gated done");
		// frozen clock enable: pulses are missed and the count holds
		apb(1'b1, `PAC_OFF_CTRL, 32'h05);
		ce <= 1'b0;
		pac_pulse_src_i.pulse(2, 4);
		ce <= 1'b1;
		rd_chk(`PAC_OFF_COUNT, 32'h4);
		$display("test freeze done");
		// gated with high inhibit: count only while the pin is low
		pac_pulse_src_i.hold(1'b1, 4);
		apb(1'b1, `PAC_OFF_CTRL, 32'h0F);
		apb(1'b1, `PAC_OFF_FLAGS, 32'h30);
		rd_chk(`PAC_OFF_CTRL, 32'h07);
		repeat (100) @(posedge clk_sys);
		rd_chk(`PAC_OFF_COUNT, 32'h5);
		pac_pulse_src_i.hold(1'b0, 128);
		pac_pulse_src_i.hold(1'b1, 8);
		rd_chk(`PAC_OFF_COUNT, 32'h7);
		rd_chk(`PAC_OFF_FLAGS, 32'h21);
		$display("test high inhibit done");
		end_of_test;
	end
endmodule // test_pac_top

`default_nettype wire
